// ==== pkg/fdce_pkg.sv ====
// Shared constants and types of the frame DMA channel engine.
// Assumes one 40 MHz clock and 32-bit wide, byte-addressed frame memory.
package fdce_pkg;
   // ------------------------------------------------------------
   // Structure
   // ------------------------------------------------------------
   localparam int NCH  = 10;
   localparam int NXTR = 2;
   localparam int NINJ = 8;
   localparam int PW   = 3;
   localparam int IW   = 4;
   localparam int DW   = 32;
   localparam int LW   = 16;
   localparam logic [IW-1:0] CH_XTR0 = 4'h0;
   localparam logic [IW-1:0] CH_XTR1 = 4'h1;
   localparam logic [IW-1:0] CH_INJ0 = 4'h2;
   localparam logic [5:0]    PORT_G0 = 6'h35;
   localparam logic [5:0]    PORT_G1 = 6'h36;
   // ------------------------------------------------------------
   // Control block layout
   // ------------------------------------------------------------
   localparam logic [31:0] NULL_PTR  = 32'h0000_0000;
   localparam logic [31:0] OFS_LLP   = 32'h0000_0000;
   localparam logic [31:0] OFS_DPTR  = 32'h0000_0004;
   localparam logic [31:0] OFS_DATAL = 32'h0000_0008;
   localparam logic [31:0] OFS_STAT  = 32'h0000_000C;
   localparam int SOF_BIT = 16;
   localparam int EOF_BIT = 17;
   localparam int ABT_BIT = 18;
   localparam int PD_BIT  = 19;
   localparam int IFH_FCS_BIT = 0;
   localparam logic [1:0] PCIE_TAG = 2'h3;
   // ------------------------------------------------------------
   // Engine states
   // ------------------------------------------------------------
   typedef enum logic [9:0] {
      ST_IDLE = 10'h001,
      ST_RLLP = 10'h002,
      ST_RDPT = 10'h004,
      ST_RDAL = 10'h008,
      ST_RSTA = 10'h010,
      ST_HDR  = 10'h020,
      ST_MOVE = 10'h040,
      ST_PUSH = 10'h080,
      ST_WSTA = 10'h100,
      ST_NEXT = 10'h200
   } fdce_state_t;
endpackage

// ==== hdl/fdce_arb.sv ====
// Strict priority arbiter over the channel requests.
// Assumes requests and priorities are stable in the evaluating cycle.
`timescale 1ns/1ps
module fdce_arb #(
   parameter int N  = fdce_pkg::NCH,
   parameter int PW = fdce_pkg::PW,
   parameter int IW = fdce_pkg::IW
) (
   input  wire logic [N-1:0]    req_i,
   input  wire logic [N*PW-1:0] prio_i,
   output logic                 gnt_vld_o,
   output logic [IW-1:0]        gnt_idx_o
);
   logic [PW-1:0] best;

   // Scanning upward with >= lets a higher channel win a tie.
   always_comb begin
      gnt_vld_o = 1'b0;
      gnt_idx_o = '0;
      best      = '0;
      for (int i = 0; i < N; i++) begin
         if (req_i[i] && (!gnt_vld_o || prio_i[i*PW +: PW] >= best)) begin
            gnt_vld_o = 1'b1;
            gnt_idx_o = IW'(i);
            best      = prio_i[i*PW +: PW];
         end
      end
   end
endmodule

// ==== hdl/fdce_chan.sv ====
// Per-channel enable, pending disable and next block pointer.
// Assumes software writes the pointer only while the channel is safe.
`timescale 1ns/1ps
module fdce_chan (
   input  wire logic        clock_i,
   input  wire logic        arst_n_i,
   input  wire logic        activate_i,
   input  wire logic        disable_i,
   input  wire logic        llp_we_i,
   input  wire logic [31:0] llp_wdata_i,
   input  wire logic        blk_done_i,
   input  wire logic [31:0] next_llp_i,
   output logic             enabled_o,
   output logic [31:0]      llp_o
);
   logic        en_ff;
   logic        pend_ff;
   logic [31:0] llp_ff;
   logic        stop;
   logic        keep;
   logic        nxt_en;
   logic        nxt_pend;
   logic [31:0] nxt_llp;

   // A stop happens only once a block has finished and its status is saved.
   assign stop = blk_done_i & (pend_ff | next_llp_i == fdce_pkg::NULL_PTR);
   assign keep = en_ff & ~stop;
   // Activation wins over a stop in the same cycle.
   assign nxt_en   = activate_i | keep;
   assign nxt_pend = ~activate_i & keep & (disable_i | pend_ff);
   assign nxt_llp  = llp_we_i ? llp_wdata_i :
                     (blk_done_i & ~stop) ? next_llp_i : llp_ff;

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         en_ff   <= 1'b0;
         pend_ff <= 1'b0;
         llp_ff  <= fdce_pkg::NULL_PTR;
      end else begin
         en_ff   <= nxt_en;
         pend_ff <= nxt_pend;
         llp_ff  <= nxt_llp;
      end
   end

   assign enabled_o = en_ff;
   assign llp_o     = llp_ff;
endmodule

// ==== hdl/fdce_engine.sv ====
// Frame DMA engine: control block walker, arbiter and data mover.
// Assumes a memory port that answers each request with a one-cycle ack.
`timescale 1ns/1ps
// ------------------------------------------------------------
// Notes on behaviour
// - Two extraction channels, one per CPU port, and eight injection channels.
// - Channel 0 extracts from CPU port 53, group 0.
// - Channel 1 extracts from CPU port 54, group 1.
// - Channels 2 to 9 inject to port 53 or 54 by group select.
// - Among requesting channels the highest priority value wins.
// - Equal priority goes to the higher channel number.
// - Injection port ownership changes only at frame boundaries, except in manual mode.
// - Each extracted frame in memory starts with its internal header.
// - Injected frame FCS is recomputed only when its header asks.
// - Manual mode bypasses arbitration and serves requests in given order.
// - Events fire on frame completion and on null next pointers.
// - Work comes from linked control blocks in DRAM or PCIe space.
// - A disable request waits until the block ends and status is saved.
// - A channel whose next pointer is null disables itself.
// ------------------------------------------------------------
module fdce_engine #(
   parameter int NCH = fdce_pkg::NCH,
   parameter int PW  = fdce_pkg::PW
) (
   input  wire logic                clock_i,
   input  wire logic                arst_n_i,
   input  wire logic [NCH-1:0]      channel_activate_i,
   input  wire logic [NCH-1:0]      channel_disable_request_i,
   input  wire logic [NCH-1:0]      next_block_pointer_we_i,
   input  wire logic [31:0]         next_block_pointer_wdata_i,
   input  wire logic [NCH-3:0]      injection_group_select_i,
   input  wire logic [NCH*PW-1:0]   channel_priority_field_i,
   input  wire logic                manual_mode_i,
   input  wire logic                manual_req_i,
   input  wire logic [3:0]          manual_ch_i,
   output logic                     manual_take_o,
   output logic                     mem_req_o,
   output logic                     mem_we_o,
   output logic [31:0]              mem_addr_o,
   output logic [31:0]              mem_wdata_o,
   output logic                     mem_pcie_sel_o,
   input  wire logic                mem_ack_i,
   input  wire logic [31:0]         mem_rdata_i,
   input  wire logic [1:0]          xtr_valid_i,
   input  wire logic [63:0]         xtr_data_i,
   input  wire logic [1:0]          xtr_eof_i,
   input  wire logic [63:0]         xtr_ifh_i,
   output logic [1:0]               xtr_ready_o,
   output logic                     inj_valid_o,
   output logic [31:0]              inj_data_o,
   output logic                     inj_sof_o,
   output logic                     inj_eof_o,
   output logic                     inj_fcs_update_o,
   output logic                     inj_group_o,
   output logic [5:0]               inj_port_o,
   input  wire logic [1:0]          inj_ready_i,
   output logic [NCH-1:0]           ch_enabled_o,
   output logic [NCH-1:0]           ch_updating_o,
   output logic [NCH-1:0]           ch_safe_o,
   output logic [NCH-1:0]           evt_llp_o,
   output logic [NCH-1:0]           evt_frm_o
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   localparam int DW = fdce_pkg::DW;
   localparam int LW = fdce_pkg::LW;
   fdce_pkg::fdce_state_t state_ff, nxt_state;
   logic [3:0]     cur_ch_ff;
   logic [31:0]    dcb_next_ff, dptr_ff, datal_ff, stat_ff, data_ff;
   logic [LW-1:0]  cnt_ff;
   logic           sof_blk_ff, eof_seen_ff, fcs_ff;
   logic [1:0]     frm_open_ff, own_vld_ff;
   logic [3:0]     own_ch_ff [2];
   logic [NCH-1:0] evt_llp_ff, evt_frm_ff;
   logic [NCH-1:0] ch_en, ch_req, ch_grp, cur_oh, done_vec;
   logic [31:0]    ch_llp [NCH];
   logic           gnt_vld, take, man_ok, cur_xtr, cur_grp, ack;
   logic [3:0]     gnt_idx, take_ch;
   logic           st_idle, st_rllp, st_rdpt, st_rdal, st_rsta;
   logic           st_hdr, st_move, st_push, st_wsta, st_next, st_dcb;
   logic [31:0]    cur_llp, data_addr, stat_wr, xtr_word;
   logic [LW-1:0]  blk_len, cnt_nx;
   logic           blk_full, last, push_ok, skip_inj, rd_sof;
   logic           llp_evt, frm_evt;

   // ------------------------------------------------------------
   // Channels and arbitration
   // ------------------------------------------------------------
   // Channels 0 and 1 are tied to groups 0 and 1; the rest follow select.
   assign ch_grp = {injection_group_select_i, 2'b10};
   assign cur_oh = {{(NCH-1){1'b0}}, 1'b1} << cur_ch_ff;
   assign done_vec = st_next ? cur_oh : '0;

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      // A locked injection port only admits its owning channel.
      assign ch_req[i] = ch_en[i] & ((i < fdce_pkg::NXTR) ?
         xtr_valid_i[ch_grp[i]] :
         (inj_ready_i[ch_grp[i]] & (~own_vld_ff[ch_grp[i]] |
          own_ch_ff[ch_grp[i]] == 4'(i))));
      fdce_chan u_ch (
         .clock_i     (clock_i),
         .arst_n_i    (arst_n_i),
         .activate_i  (channel_activate_i[i]),
         .disable_i   (channel_disable_request_i[i]),
         .llp_we_i    (next_block_pointer_we_i[i]),
         .llp_wdata_i (next_block_pointer_wdata_i),
         .blk_done_i  (done_vec[i]),
         .next_llp_i  (dcb_next_ff),
         .enabled_o   (ch_en[i]),
         .llp_o       (ch_llp[i])
      );
   end

   fdce_arb #(.N(NCH), .PW(PW), .IW(fdce_pkg::IW)) u_arb (
      .req_i     (ch_req),
      .prio_i    (channel_priority_field_i),
      .gnt_vld_o (gnt_vld),
      .gnt_idx_o (gnt_idx)
   );

   // Manual mode replaces the arbiter with the processor's own choice.
   assign man_ok  = manual_req_i & (manual_ch_i < 4'(NCH)) &&
                    ch_en[manual_ch_i];
   assign take    = st_idle & (manual_mode_i ? man_ok : gnt_vld);
   assign take_ch = manual_mode_i ? manual_ch_i : gnt_idx;
   assign manual_take_o = st_idle & manual_mode_i & man_ok;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   assign st_idle = state_ff == fdce_pkg::ST_IDLE;
   assign st_rllp = state_ff == fdce_pkg::ST_RLLP;
   assign st_rdpt = state_ff == fdce_pkg::ST_RDPT;
   assign st_rdal = state_ff == fdce_pkg::ST_RDAL;
   assign st_rsta = state_ff == fdce_pkg::ST_RSTA;
   assign st_hdr  = state_ff == fdce_pkg::ST_HDR;
   assign st_move = state_ff == fdce_pkg::ST_MOVE;
   assign st_push = state_ff == fdce_pkg::ST_PUSH;
   assign st_wsta = state_ff == fdce_pkg::ST_WSTA;
   assign st_next = state_ff == fdce_pkg::ST_NEXT;
   assign st_dcb  = st_rllp | st_rdpt | st_rdal | st_rsta;

   assign cur_xtr  = cur_ch_ff < fdce_pkg::CH_INJ0;
   assign cur_grp  = ch_grp[cur_ch_ff];
   assign cur_llp  = ch_llp[cur_ch_ff];
   assign blk_len  = cur_xtr ? datal_ff[LW-1:0] : stat_ff[LW-1:0];
   assign cnt_nx   = cnt_ff + {{(LW-1){1'b0}}, 1'b1};
   assign blk_full = cnt_ff >= blk_len;
   assign last     = cnt_nx == blk_len;
   assign xtr_word = xtr_data_i[cur_grp*DW +: DW];
   assign data_addr = dptr_ff + 32'({cnt_ff, 2'b00});
   assign push_ok  = st_push & inj_ready_i[cur_grp];
   assign rd_sof   = mem_rdata_i[fdce_pkg::SOF_BIT];
   // Aborted, already done or empty injection blocks move no data.
   assign skip_inj = mem_rdata_i[fdce_pkg::ABT_BIT] |
                     mem_rdata_i[fdce_pkg::PD_BIT] |
                     (mem_rdata_i[LW-1:0] == '0);
   assign stat_wr  = cur_xtr ?
      {stat_ff[31:fdce_pkg::EOF_BIT+1], eof_seen_ff, sof_blk_ff, cnt_ff} :
      (stat_ff | (32'h0000_0001 << fdce_pkg::PD_BIT));

   // ------------------------------------------------------------
   // Memory port
   // ------------------------------------------------------------
   assign mem_req_o = st_dcb | st_hdr | st_wsta | (st_move & (cur_xtr ?
                      (xtr_valid_i[cur_grp] & ~blk_full) : 1'b1));
   assign mem_we_o  = st_hdr | st_wsta | (st_move & cur_xtr);
   assign mem_addr_o = st_rllp ? cur_llp + fdce_pkg::OFS_LLP :
                       st_rdpt ? cur_llp + fdce_pkg::OFS_DPTR :
                       st_rdal ? cur_llp + fdce_pkg::OFS_DATAL :
                       (st_rsta | st_wsta) ? cur_llp + fdce_pkg::OFS_STAT :
                       data_addr;
   assign mem_wdata_o = st_hdr ? xtr_ifh_i[cur_grp*DW +: DW] :
                        st_wsta ? stat_wr : xtr_word;
   assign mem_pcie_sel_o = mem_addr_o[31:30] == fdce_pkg::PCIE_TAG;
   assign ack = mem_req_o & mem_ack_i;
   assign xtr_ready_o = (st_move & cur_xtr & ack) ?
                        (cur_grp ? 2'b10 : 2'b01) : 2'b00;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         fdce_pkg::ST_IDLE: if (take) nxt_state = fdce_pkg::ST_RLLP;
         fdce_pkg::ST_RLLP: if (ack) nxt_state = fdce_pkg::ST_RDPT;
         fdce_pkg::ST_RDPT: if (ack) nxt_state = fdce_pkg::ST_RDAL;
         fdce_pkg::ST_RDAL: if (ack) nxt_state = fdce_pkg::ST_RSTA;
         fdce_pkg::ST_RSTA: if (ack) begin
            if (cur_xtr)
               nxt_state = frm_open_ff[cur_grp] ? fdce_pkg::ST_MOVE :
                                                 fdce_pkg::ST_HDR;
            else
               nxt_state = skip_inj ? fdce_pkg::ST_WSTA : fdce_pkg::ST_MOVE;
         end
         fdce_pkg::ST_HDR: if (ack) nxt_state = fdce_pkg::ST_MOVE;
         fdce_pkg::ST_MOVE: begin
            if (!cur_xtr) begin
               if (ack) nxt_state = fdce_pkg::ST_PUSH;
            end else if (blk_full || (ack && (xtr_eof_i[cur_grp] || last)))
               nxt_state = fdce_pkg::ST_WSTA;
         end
         fdce_pkg::ST_PUSH: if (push_ok)
            nxt_state = last ? fdce_pkg::ST_WSTA : fdce_pkg::ST_MOVE;
         fdce_pkg::ST_WSTA: if (ack) nxt_state = fdce_pkg::ST_NEXT;
         fdce_pkg::ST_NEXT: nxt_state = fdce_pkg::ST_IDLE;
         default: nxt_state = fdce_pkg::ST_IDLE;
      endcase
   end

   assign llp_evt = (st_rllp & ack & cur_xtr &
                     mem_rdata_i == fdce_pkg::NULL_PTR) |
                    (st_next & ~cur_xtr &
                     dcb_next_ff == fdce_pkg::NULL_PTR);
   assign frm_evt = st_next & eof_seen_ff;

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_ff    <= fdce_pkg::ST_IDLE;
         cur_ch_ff   <= fdce_pkg::CH_XTR0;
         dcb_next_ff <= fdce_pkg::NULL_PTR;
         dptr_ff     <= '0;
         datal_ff    <= '0;
         stat_ff     <= '0;
         data_ff     <= '0;
         cnt_ff      <= '0;
         sof_blk_ff  <= 1'b0;
         eof_seen_ff <= 1'b0;
         fcs_ff      <= 1'b0;
         evt_llp_ff  <= '0;
         evt_frm_ff  <= '0;
      end else begin
         state_ff   <= nxt_state;
         evt_llp_ff <= llp_evt ? cur_oh : '0;
         evt_frm_ff <= frm_evt ? cur_oh : '0;
         if (take) cur_ch_ff <= take_ch;
         if (st_rllp & ack) dcb_next_ff <= mem_rdata_i;
         if (st_rdpt & ack) dptr_ff <= mem_rdata_i;
         if (st_rdal & ack) datal_ff <= mem_rdata_i;
         if (st_rsta & ack) begin
            stat_ff     <= mem_rdata_i;
            cnt_ff      <= '0;
            sof_blk_ff  <= ~cur_xtr & rd_sof;
            eof_seen_ff <= ~cur_xtr & mem_rdata_i[fdce_pkg::EOF_BIT];
         end
         if ((st_hdr | (st_move & cur_xtr)) & ack) cnt_ff <= cnt_nx;
         if (push_ok) cnt_ff <= cnt_nx;
         if (st_hdr & ack) sof_blk_ff <= 1'b1;
         if (st_move & cur_xtr & ack & xtr_eof_i[cur_grp])
            eof_seen_ff <= 1'b1;
         if (st_move & ~cur_xtr & ack) data_ff <= mem_rdata_i;
         if (st_move & ~cur_xtr & ack & sof_blk_ff & cnt_ff == '0)
            fcs_ff <= mem_rdata_i[fdce_pkg::IFH_FCS_BIT];
      end
   end

   // Frame state per CPU port: open extraction frames and injection owners.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         frm_open_ff <= 2'b00;
         own_vld_ff  <= 2'b00;
         own_ch_ff   <= '{default: 4'h0};
      end else begin
         if (st_hdr & ack) frm_open_ff[cur_grp] <= 1'b1;
         if (st_next & cur_xtr & eof_seen_ff) frm_open_ff[cur_grp] <= 1'b0;
         if (st_rsta & ack & ~cur_xtr & rd_sof) begin
            own_vld_ff[cur_grp] <= 1'b1;
            own_ch_ff[cur_grp]  <= cur_ch_ff;
         end
         if (st_next & ~cur_xtr & eof_seen_ff)
            own_vld_ff[cur_grp] <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign inj_valid_o      = st_push;
   assign inj_data_o       = data_ff;
   assign inj_sof_o        = st_push & sof_blk_ff & cnt_ff == '0;
   assign inj_eof_o        = st_push & eof_seen_ff & last;
   assign inj_fcs_update_o = fcs_ff;
   assign inj_group_o      = cur_grp;
   assign inj_port_o = cur_grp ? fdce_pkg::PORT_G1 : fdce_pkg::PORT_G0;
   assign ch_enabled_o  = ch_en;
   assign ch_updating_o = (st_dcb | st_wsta) ? cur_oh : '0;
   assign ch_safe_o     = ~ch_en;
   assign evt_llp_o     = evt_llp_ff;
   assign evt_frm_o     = evt_frm_ff;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   logic       arb_hi_ok, arb_tie_ok;
   logic [PW-1:0] gp;
   assign gp = channel_priority_field_i[gnt_idx*PW +: PW];
   always_comb begin
      arb_hi_ok  = 1'b1;
      arb_tie_ok = 1'b1;
      for (int j = 0; j < NCH; j++) begin
         if (ch_req[j] && channel_priority_field_i[j*PW +: PW] > gp)
            arb_hi_ok = 1'b0;
         if (ch_req[j] && channel_priority_field_i[j*PW +: PW] == gp &&
             j > int'(gnt_idx))
            arb_tie_ok = 1'b0;
      end
   end

   sequence s_hdr_due;
      st_rsta && ack && cur_xtr && !frm_open_ff[cur_grp];
   endsequence
   sequence s_hdr_write;
      st_hdr && mem_we_o ##0 !frm_open_ff[cur_grp];
   endsequence

   arb_priority_a: assert property (gnt_vld |-> arb_hi_ok)
      else $error("Lower priority channel granted.");
   arb_tie_a: assert property (gnt_vld |-> arb_tie_ok)
      else $error("Tie not given to higher channel.");
   idle_grant_a: assert property (st_idle && gnt_vld && !manual_mode_i
      |=> st_rllp && cur_ch_ff == $past(gnt_idx))
      else $error("Grant not taken in one cycle.");
   xtr0_port_a: assert property (st_move && ack &&
      cur_ch_ff == fdce_pkg::CH_XTR0 |-> xtr_ready_o == 2'b01)
      else $error("Channel 0 not on group 0.");
   xtr1_port_a: assert property (st_move && ack &&
      cur_ch_ff == fdce_pkg::CH_XTR1 |-> xtr_ready_o == 2'b10)
      else $error("Channel 1 not on group 1.");
   inj_group_a: assert property (st_push |-> inj_group_o ==
      injection_group_select_i[3'(cur_ch_ff - fdce_pkg::CH_INJ0)])
      else $error("Injection group mismatch.");
   own_hold_a: assert property (st_rllp && !cur_xtr &&
      own_vld_ff[cur_grp] |-> cur_ch_ff == own_ch_ff[cur_grp])
      else $error("Port ownership changed mid frame.");
   hdr_first_a: assert property (s_hdr_due |=> s_hdr_write)
      else $error("Header not written first.");
   fcs_req_a: assert property (inj_sof_o |->
      inj_fcs_update_o == data_ff[fdce_pkg::IFH_FCS_BIT])
      else $error("FCS flag does not follow header.");
   manual_order_a: assert property (manual_take_o
      |=> st_rllp && cur_ch_ff == $past(manual_ch_i))
      else $error("Manual request not served.");
   frm_event_a: assert property (st_next && eof_seen_ff
      |=> evt_frm_o == $past(cur_oh) ##1 evt_frm_o == '0)
      else $error("Frame event missing.");
   no_early_stop_a: assert property ((~ch_en & $past(ch_en) &
      ~$past(done_vec)) == '0)
      else $error("Channel stopped mid block.");
   null_stop_a: assert property (st_next &&
      dcb_next_ff == fdce_pkg::NULL_PTR && !channel_activate_i[cur_ch_ff]
      |=> !ch_en[cur_ch_ff])
      else $error("Null pointer did not stop channel.");
endmodule

// ==== testbench/fdce_mem_model.sv ====
// Partner model: frame memory behind the engine and CPU port readiness.
// Assumes byte addresses below 0x100; slow_i makes it answer every other cycle.
`timescale 1ns/1ps
module fdce_mem_model (
   input  wire logic        clock_i,
   input  wire logic        slow_i,
   input  wire logic        mem_req_i,
   input  wire logic        mem_we_i,
   input  wire logic [31:0] mem_addr_i,
   input  wire logic [31:0] mem_wdata_i,
   output logic             mem_ack_o,
   output logic [31:0]      mem_rdata_o,
   output logic [1:0]       inj_ready_o
);
   logic [31:0] mem [64];
   logic        tog_ff = 1'b0;
   logic        go;
   logic [31:0] word;
   assign go          = ~slow_i | tog_ff;
   assign word        = mem[mem_addr_i[7:2]];
   assign mem_ack_o   = mem_req_i & go;
   // Read data is inverted outside an answer, so a stale word never matches.
   assign mem_rdata_o = mem_ack_o ? word : ~word;
   assign inj_ready_o = {2{go}};
   always @(posedge clock_i) begin
      tog_ff <= ~tog_ff;
      if (mem_ack_o & mem_we_i)
         mem[mem_addr_i[7:2]] <= mem_wdata_i;
   end
endmodule

// ==== testbench/frame_dma_channel_engine_bench.sv ====
// Bench for the frame DMA engine: injection, arbitration, extraction.
// Assumes the memory model holds every control block and frame word.
`timescale 1ns/1ps
module frame_dma_channel_engine_bench;
   typedef struct packed {logic [3:0] ch; logic [5:0] port;} fdce_row_t;
   fdce_row_t rows [8] = '{'{4'h2, 6'h35}, '{4'h3, 6'h36}, '{4'h4, 6'h35},
      '{4'h5, 6'h36}, '{4'h6, 6'h35}, '{4'h7, 6'h36}, '{4'h8, 6'h35},
      '{4'h9, 6'h36}};
   logic        clock_i = 1'b0, arst_n_i = 1'b0, mm = 1'b0, slow = 1'b0;
   logic [9:0]  act = 10'h000, we = 10'h000;
   logic [31:0] wdata = 32'h0;
   logic [7:0]  grp = 8'h00;
   logic [29:0] pri = 30'h0;
   logic [3:0]  mch = 4'h0;
   logic [1:0]  xv = 2'h0, rdy, xrdy;
   logic [63:0] xd = 64'h0, xh = 64'h0;
   logic        req, mwe, ack, iv, isof, ieof, ifcs, igrp;
   logic [31:0] addr, mwd, rd, idat;
   logic [5:0]  iport;
   logic [9:0]  en, ellp, efrm, safe, dis = 10'h000;
   logic [1:0]  xtr_gm = 2'h0, inj_gm = 2'h0;
   logic [3:0]  gap = 4'h1;
   logic        fmt = 1'b0, nopre = 1'b0, stk = 1'b1, inj_ok;
   // The queue side only offers or accepts frames once its ports are set up.
   assign inj_ok = inj_gm == 2'h2 && gap == 4'h0 && fmt && nopre && !stk;
   int          error_cnt = 0, check_count = 0, cyc = 0, i, g;
   fdce_engine u_dut (.clock_i, .arst_n_i, .channel_activate_i(act),
      .channel_disable_request_i(dis), .next_block_pointer_we_i(we),
      .next_block_pointer_wdata_i(wdata), .injection_group_select_i(grp),
      .channel_priority_field_i(pri), .manual_mode_i(mm), .manual_req_i(mm),
      .manual_ch_i(mch), .manual_take_o(), .mem_req_o(req), .mem_we_o(mwe),
      .mem_addr_o(addr), .mem_wdata_o(mwd), .mem_pcie_sel_o(),
      .mem_ack_i(ack), .mem_rdata_i(rd), .xtr_data_i(xd),
      .xtr_valid_i(xv & {2{xtr_gm == 2'h2}}),
      .xtr_eof_i(2'h3), .xtr_ifh_i(xh), .xtr_ready_o(xrdy),
      .inj_valid_o(iv), .inj_data_o(idat), .inj_sof_o(isof),
      .inj_eof_o(ieof), .inj_fcs_update_o(ifcs), .inj_group_o(igrp),
      .inj_port_o(iport), .inj_ready_i(rdy & {2{inj_ok}}), .ch_enabled_o(en),
      .ch_updating_o(), .ch_safe_o(safe), .evt_llp_o(ellp), .evt_frm_o(efrm));
   fdce_mem_model u_mem (.clock_i, .slow_i(slow), .mem_req_i(req),
      .mem_we_i(mwe), .mem_addr_i(addr), .mem_wdata_i(mwd),
      .mem_ack_o(ack), .mem_rdata_o(rd), .inj_ready_o(rdy));
   initial forever #12.5 clock_i = ~clock_i;
   task automatic finish_test;
      if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         chk(32'h1, 32'h0);
         finish_test;
      end
   end
   task automatic inj(input logic [9:0] a, input logic [29:0] pr,
                      input logic m, input logic [3:0] c, input logic [5:0] p);
      int k;
      for (k = 2; k < 10; k++) begin
         u_mem.mem[4*k] = 32'h0;
         u_mem.mem[4*k+1] = 32'hC0 + 4 * k;
         u_mem.mem[4*k+2] = 32'h1;
         u_mem.mem[4*k+3] = 32'h0003_0001;
         u_mem.mem[48+k] = 32'hD000_0000 + k;
         if (a[k]) begin
            @(posedge clock_i);
            we <= 10'h001 << k;
            wdata <= 32'h10 * k;
            pri <= pr;
            mm <= m;
            mch <= c;
         end
      end
      @(posedge clock_i) we <= 10'h000;
      act <= a;
      @(posedge clock_i) act <= 10'h000;
      for (k = 0; k < 300 && iv !== 1'b1; k++) @(negedge clock_i);
      chk(idat, 32'hD000_0000 + c);
      chk({iport, igrp, ifcs, isof, ieof}, {p, ~p[0], c[0], 2'b11});
      @(posedge clock_i) mm <= 1'b0;
      for (k = 0; k < 300 && efrm[c] !== 1'b1; k++) @(negedge clock_i);
      chk(ellp[c], 1'b1);
      for (k = 0; k < 900 && en !== 10'h000; k++) @(negedge clock_i);
      chk(en, 10'h000);
   endtask
   initial begin
      repeat (20) @(posedge clock_i);
      arst_n_i <= 1'b1;
      grp <= 8'hAA;
      xtr_gm <= 2'h2;
      inj_gm <= 2'h2;
      gap <= 4'h0;
      fmt <= 1'b1;
      nopre <= 1'b1;
      stk <= 1'b0;
      for (i = 0; i < 8; i++)
         inj(10'h001 << rows[i].ch, 30'h0, 1'b0, rows[i].ch, rows[i].port);
      // Channels 3 and 5 tie at value 2 above channel 9; the higher channel number must win.
      inj(10'h228, (30'h2 << 9) | (30'h2 << 15) | (30'h1 << 27), 1'b0,
          4'h5, 6'h36);
      slow <= 1'b1;
      inj(10'h150, (30'h5 << 12) | (30'h1 << 18), 1'b0, 4'h4, 6'h35);
      inj(10'h044, 30'h7 << 18, 1'b1, 4'h2, 6'h35);
      slow <= 1'b0;
      for (g = 0; g < 2; g++) begin
         u_mem.mem[4*g] = 32'h0;
         u_mem.mem[4*g+1] = 32'hE8;
         u_mem.mem[4*g+2] = 32'h4;
         u_mem.mem[4*g+3] = 32'h0;
         @(posedge clock_i) we <= 10'h001 << g;
         wdata <= 32'h10 * g;
         xv <= 2'h1 << g;
         xd <= {2{32'h1111_2222 + g}};
         xh <= {2{32'hCAFE_0001 + g}};
         @(posedge clock_i) we <= 10'h000;
         act <= 10'h001 << g;
         @(posedge clock_i) act <= 10'h000;
         for (i = 0; i < 300 && xrdy[g] !== 1'b1; i++) @(negedge clock_i);
         @(posedge clock_i) xv <= 2'h0;
         for (i = 0; i < 300 && en[g] !== 1'b0; i++) @(negedge clock_i);
         chk(u_mem.mem[58], 32'hCAFE_0001 + g);
         chk(u_mem.mem[59], 32'h1111_2222 + g);
      end
      // A self-linked block loops forever unless the pending disable holds.
      u_mem.mem[8] = 32'h20;
      u_mem.mem[11] = 32'h0003_0001;
      @(posedge clock_i) we <= 10'h004;
      wdata <= 32'h20;
      @(posedge clock_i) we <= 10'h000;
      act <= 10'h004;
      @(posedge clock_i) act <= 10'h000;
      dis <= 10'h004;
      @(posedge clock_i) dis <= 10'h000;
      for (i = 0; i < 300 && en[2] !== 1'b0; i++) @(negedge clock_i);
      chk(en, 10'h000);
      chk(safe, 10'h3FF);
      chk(u_mem.mem[11], 32'h000B_0001);
      finish_test;
   end
endmodule
